// ==== core/pewc_ctrl.sv ====
// Host-side controller for a parallel byte-wide EEPROM: read, write with completion
// polling, identification-row access and chip clear. Assumes the data pins return to
// this clock synchronously and that external drivers turn the hv flags into 12 V.
`timescale 1ns/100ps
module pewc_ctrl #(
    parameter int TIMEOUT_CYCLES = int'(pewc_pkg::CYC_TIMEOUT),
    parameter int CLEAR_CYCLES   = int'(pewc_pkg::CYC_CLEAR)
) (
    // Clock and reset
    input  wire logic                           i_clk,
    input  wire logic                           i_resetn,
    // Request side
    input  wire logic                           i_req_valid,
    input  wire pewc_pkg::pewc_req_type         i_req,
    output logic                                o_req_ready,
    output logic                                o_rsp_valid,
    output pewc_pkg::pewc_rsp_type              o_rsp,
    // Memory pins
    output pewc_pkg::pewc_pins_type             o_pins,
    input  wire logic [pewc_pkg::DATA_W-1:0]    i_data_in
);
    initial begin
        if (TIMEOUT_CYCLES < 1 || TIMEOUT_CYCLES >= (1 << pewc_pkg::LONG_W)
            || CLEAR_CYCLES < 1 || CLEAR_CYCLES >= (1 << pewc_pkg::LONG_W)) begin
            $error("pewc_ctrl: cycle count parameter out of range");
        end
    end

    typedef enum {
        IDLE, W_SETUP, W_LOW, W_HIGH, P_SETUP, P_SAMPLE, P_GAP,
        R_SETUP, R_SAMPLE, C_SETUP, C_LOW, C_HOLD, DONE
    } pewc_state_type;

    localparam logic [pewc_pkg::CNT_W-1:0]  SETUP_C = pewc_pkg::CNT_W'(pewc_pkg::CYC_SETUP);
    localparam logic [pewc_pkg::CNT_W-1:0]  WPL_C   = pewc_pkg::CNT_W'(pewc_pkg::CYC_WPL);
    localparam logic [pewc_pkg::CNT_W-1:0]  WPH_C   = pewc_pkg::CNT_W'(pewc_pkg::CYC_WPH);
    localparam logic [pewc_pkg::CNT_W-1:0]  READ_C  = pewc_pkg::CNT_W'(pewc_pkg::CYC_READ);
    localparam logic [pewc_pkg::LONG_W-1:0] TOUT_C  = pewc_pkg::LONG_W'(TIMEOUT_CYCLES);
    localparam logic [pewc_pkg::LONG_W-1:0] CLR_C   = pewc_pkg::LONG_W'(CLEAR_CYCLES);

    logic                          rst_meta;
    logic                          rst_n;
    pewc_state_type                state;
    pewc_state_type                next_state;
    logic [pewc_pkg::CNT_W-1:0]    cnt;
    logic [pewc_pkg::LONG_W-1:0]   long_cnt;
    pewc_pkg::pewc_req_type        req;
    pewc_pkg::pewc_req_type        next_req;
    logic                          phase_done;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    function automatic logic [pewc_pkg::CNT_W-1:0] phase_len(input pewc_state_type s);
        case (s)
            W_LOW:            phase_len = WPL_C;
            W_HIGH, P_GAP:    phase_len = WPH_C;
            P_SAMPLE, R_SAMPLE: phase_len = READ_C;
            default:          phase_len = SETUP_C;
        endcase
    endfunction : phase_len

    assign phase_done  = (cnt == pewc_pkg::CNT_W'(1));
    // Ready waits for the internal reset copy, so no request is lost while it is released.
    assign o_req_ready = (state == IDLE) && rst_n;

    always_comb begin
        next_state = state;
        case (state)
            IDLE: begin
                if (i_req_valid && o_req_ready) begin
                    case (i_req.cmd)
                        pewc_pkg::PEWC_CMD_WRITE: next_state = W_SETUP;
                        pewc_pkg::PEWC_CMD_CLEAR: next_state = C_SETUP;
                        default:                  next_state = R_SETUP;
                    endcase
                end
            end
            W_SETUP:  next_state = phase_done ? W_LOW : W_SETUP;
            W_LOW:    next_state = phase_done ? W_HIGH : W_LOW;
            W_HIGH:   next_state = phase_done ? P_SETUP : W_HIGH;
            P_SETUP:  next_state = phase_done ? P_SAMPLE : P_SETUP;
            P_SAMPLE: begin
                if (phase_done) begin
                    // Poll until the flag bit matches what was written.
                    if (i_data_in[pewc_pkg::POLL_BIT] == req.data[pewc_pkg::POLL_BIT]) begin
                        next_state = DONE;
                    end else if (long_cnt == '0) begin
                        next_state = DONE;
                    end else begin
                        next_state = P_GAP;
                    end
                end
            end
            P_GAP:    next_state = phase_done ? P_SAMPLE : P_GAP;
            R_SETUP:  next_state = phase_done ? R_SAMPLE : R_SETUP;
            R_SAMPLE: next_state = phase_done ? DONE : R_SAMPLE;
            C_SETUP:  next_state = phase_done ? C_LOW : C_SETUP;
            C_LOW:    next_state = (long_cnt == '0) ? C_HOLD : C_LOW;
            C_HOLD:   next_state = phase_done ? DONE : C_HOLD;
            DONE:     next_state = IDLE;
            default:  next_state = IDLE;
        endcase
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Phase counter reloads on every state change.
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= '0;
        end else if (next_state != state) begin
            cnt <= phase_len(next_state);
        end else if (cnt != '0) begin
            cnt <= cnt - pewc_pkg::CNT_W'(1);
        end
    end

    // Long counter bounds the polling time and times the chip clear pulse.
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            long_cnt <= '0;
        end else if (state == W_HIGH) begin
            long_cnt <= TOUT_C;
        end else if (state == C_SETUP) begin
            long_cnt <= CLR_C;
        end else if (long_cnt != '0 && (state == C_LOW || state == P_SAMPLE || state == P_GAP)) begin
            long_cnt <= long_cnt - pewc_pkg::LONG_W'(1);
        end
    end

    // The pins follow the incoming request at once, so the address settles a cycle before the strobe falls.
    always_comb begin
        next_req = req;
        if (i_req_valid && o_req_ready) begin
            next_req = i_req;
            if (i_req.id_row) begin
                next_req.addr = (i_req.addr & ~pewc_pkg::ID_ROW_MASK) | pewc_pkg::ID_ROW_BASE;
            end
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            req <= '0;
        end else begin
            req <= next_req;
        end
    end

    // Pin drive. Idle keeps select and strobe high so no write can start.
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_pins.chip_sel_n       <= 1'b1;
            o_pins.out_gate_n       <= 1'b1;
            o_pins.out_gate_hv      <= 1'b0;
            o_pins.write_n          <= 1'b1;
            o_pins.id_row_hv_select <= 1'b0;
            o_pins.addr             <= '0;
            o_pins.data_out         <= '0;
            o_pins.data_oe_n        <= 1'b1;
        end else begin
            o_pins.addr             <= next_req.addr;
            o_pins.data_out         <= next_req.data;
            o_pins.id_row_hv_select <= next_req.id_row && next_state != IDLE && next_state != DONE;
            case (next_state)
                W_SETUP, W_LOW, W_HIGH: begin
                    // Gate stays high across the rising strobe edge.
                    o_pins.chip_sel_n  <= 1'b0;
                    o_pins.out_gate_n  <= 1'b1;
                    o_pins.out_gate_hv <= 1'b0;
                    o_pins.write_n     <= (next_state != W_LOW);
                    o_pins.data_oe_n   <= 1'b0;
                end
                P_SETUP, P_SAMPLE, R_SETUP, R_SAMPLE: begin
                    o_pins.chip_sel_n  <= 1'b0;
                    o_pins.out_gate_n  <= 1'b0;
                    o_pins.out_gate_hv <= 1'b0;
                    o_pins.write_n     <= 1'b1;
                    o_pins.data_oe_n   <= 1'b1;
                end
                C_SETUP, C_LOW, C_HOLD: begin
                    // Clear drives the row select from the request's id_row bit like any other command; it stays low only when id_row is 0.
                    o_pins.chip_sel_n  <= 1'b0;
                    o_pins.out_gate_n  <= 1'b1;
                    o_pins.out_gate_hv <= 1'b1;
                    o_pins.write_n     <= (next_state != C_LOW);
                    o_pins.data_oe_n   <= 1'b1;
                end
                default: begin
                    o_pins.chip_sel_n  <= 1'b1;
                    o_pins.out_gate_n  <= 1'b1;
                    o_pins.out_gate_hv <= 1'b0;
                    o_pins.write_n     <= 1'b1;
                    o_pins.data_oe_n   <= 1'b1;
                end
            endcase
        end
    end

    // Response. A supply-starved device never completes, so polling times out.
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_rsp_valid <= 1'b0;
            o_rsp       <= '0;
        end else begin
            o_rsp_valid <= (next_state == DONE);
            if (state == R_SAMPLE && phase_done) begin
                o_rsp <= '{ok: 1'b1, timeout: 1'b0, data: i_data_in};
            end else if (state == P_SAMPLE && phase_done && next_state == DONE) begin
                o_rsp.ok      <= (i_data_in[pewc_pkg::POLL_BIT] == req.data[pewc_pkg::POLL_BIT]);
                o_rsp.timeout <= (i_data_in[pewc_pkg::POLL_BIT] != req.data[pewc_pkg::POLL_BIT]);
                o_rsp.data    <= i_data_in;
            end else if (state == C_HOLD && phase_done) begin
                o_rsp <= '{ok: 1'b1, timeout: 1'b0, data: '0};
            end
        end
    end
endmodule : pewc_ctrl

// ==== core/pewc_pkg.sv ====
// Package for the parallel EEPROM write controller: pin bundles, commands, timing.
// Assumes a 10 MHz system clock; all counts are derived from it.
package pewc_pkg;
    localparam int          CLK_HZ        = 10_000_000;
    localparam int          ADDR_W        = 11;
    localparam int          DATA_W        = 8;
    localparam int          POLL_BIT      = 7;
    // Strobe and setup times in ns, rounded up to cycles; the timeout is rounded down.
    localparam int          T_SETUP_NS    = 50;
    localparam int          T_WPL_NS      = 100;
    localparam int          T_WPH_NS      = 50;
    localparam int          T_READ_NS     = 250;
    localparam int          T_CLEAR_NS    = 10_000_000;
    localparam int          T_TIMEOUT_NS  = 2_000_000;
    localparam int          NS_PER_S      = 1_000_000_000;
    localparam longint      CYC_SETUP     = ((longint'(T_SETUP_NS) * CLK_HZ) + NS_PER_S - 1) / NS_PER_S;
    localparam longint      CYC_WPL       = ((longint'(T_WPL_NS) * CLK_HZ) + NS_PER_S - 1) / NS_PER_S;
    localparam longint      CYC_WPH       = ((longint'(T_WPH_NS) * CLK_HZ) + NS_PER_S - 1) / NS_PER_S;
    localparam longint      CYC_READ      = ((longint'(T_READ_NS) * CLK_HZ) + NS_PER_S - 1) / NS_PER_S;
    localparam longint      CYC_CLEAR     = ((longint'(T_CLEAR_NS) * CLK_HZ) + NS_PER_S - 1) / NS_PER_S;
    localparam longint      CYC_TIMEOUT   = (longint'(T_TIMEOUT_NS) * CLK_HZ) / NS_PER_S;
    localparam int          CNT_W         = 16;
    localparam int          LONG_W        = 24;
    // Identification row occupies the top 32 locations.
    localparam logic [10:0] ID_ROW_BASE   = 11'h7e0;
    localparam logic [10:0] ID_ROW_MASK   = 11'h7e0;

    typedef enum logic [1:0] {
        PEWC_CMD_READ,
        PEWC_CMD_WRITE,
        PEWC_CMD_CLEAR
    } pewc_cmd_type;

    typedef struct packed {
        pewc_cmd_type        cmd;
        logic                id_row;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   data;
    } pewc_req_type;

    // Pins driven toward the memory; all strobes are active low.
    typedef struct packed {
        logic                chip_sel_n;
        logic                out_gate_n;
        logic                out_gate_hv;
        logic                write_n;
        logic                id_row_hv_select;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   data_out;
        logic                data_oe_n;
    } pewc_pins_type;

    typedef struct packed {
        logic                ok;
        logic                timeout;
        logic [DATA_W-1:0]   data;
    } pewc_rsp_type;
endpackage : pewc_pkg

// ==== tb/pewc_ctrl_sva.sv ====
// Checker for the EEPROM write controller: pin sequencing and poll results.
// Assumes it is bound to pewc_ctrl and sees only its ports.
`timescale 1ns/100ps
module pewc_ctrl_sva #(
    parameter int TIMEOUT_CYCLES = 50,
    parameter int CLEAR_CYCLES   = 4
) (
    // Watched ports
    input wire logic                    i_clk,
    input wire logic                    i_resetn,
    input wire logic                    i_req_valid,
    input wire pewc_pkg::pewc_req_type  i_req,
    input wire logic                    o_req_ready,
    input wire logic                    o_rsp_valid,
    input wire pewc_pkg::pewc_rsp_type  o_rsp,
    input wire pewc_pkg::pewc_pins_type o_pins,
    input wire logic [7:0]              i_data_in
);
    logic wr_op;
    logic wr_bit;
    logic seen;
    // A good write answer is only legal once the device has shown the written bit 7.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wr_op  <= 1'b0;
            wr_bit <= 1'b0;
            seen   <= 1'b0;
        end else if (i_req_valid && o_req_ready) begin
            wr_op  <= i_req.cmd == pewc_pkg::PEWC_CMD_WRITE;
            wr_bit <= i_req.data[7];
            seen   <= 1'b0;
        end else if (wr_op && !o_pins.out_gate_n && i_data_in[7] == wr_bit) begin
            seen <= 1'b1;
        end
    end
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);
    a_strobe_select: assert property (!o_pins.write_n |-> !o_pins.chip_sel_n)
        else $error("strobe unselected");
    a_write_gate: assert property (!o_pins.write_n && !o_pins.out_gate_hv |-> o_pins.out_gate_n)
        else $error("gate low");
    a_idle_quiet: assert property (o_req_ready && $past(o_req_ready)
        |-> o_pins.write_n && o_pins.chip_sel_n && !o_pins.out_gate_hv) else $error("idle strobe");
    a_strobe_pulse: assert property ($fell(o_pins.write_n) && !o_pins.data_oe_n |=> o_pins.write_n)
        else $error("strobe width");
    a_addr_held: assert property ($fell(o_pins.write_n) |-> $stable(o_pins.addr))
        else $error("addr moved");
    a_data_held: assert property ($rose(o_pins.write_n) && !$past(o_pins.out_gate_hv)
        |-> !o_pins.data_oe_n && $stable(o_pins.data_out)) else $error("data moved");
    a_read_release: assert property (!o_pins.out_gate_n |-> o_pins.data_oe_n && o_pins.write_n)
        else $error("bus clash");
    a_id_top_addr: assert property (o_pins.id_row_hv_select && !o_pins.chip_sel_n |-> &o_pins.addr[10:5])
        else $error("id addr");
    a_clear_strobe: assert property ($rose(o_pins.out_gate_hv)
        |-> ##[0:3] (!o_pins.write_n && !o_pins.chip_sel_n)) else $error("clear pins");
    a_poll_match: assert property (o_rsp_valid && o_rsp.ok && wr_op |-> seen)
        else $error("early done");
    c_write_ok: cover property (o_rsp_valid && o_rsp.ok && wr_op);
    c_clear: cover property ($rose(o_pins.out_gate_hv));
    c_timeout: cover property (o_rsp_valid && o_rsp.timeout);
endmodule : pewc_ctrl_sva
bind pewc_ctrl pewc_ctrl_sva #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES), .CLEAR_CYCLES(CLEAR_CYCLES)) u_sva (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(o_req_ready),
    .o_rsp_valid(o_rsp_valid), .o_rsp(o_rsp), .o_pins(o_pins), .i_data_in(i_data_in));

// ==== tb/pewc_mem_model.sv ====
// Behavioural byte-wide EEPROM with self-timed writes, id row and chip clear.
// Assumes pins move just after i_clk edges; timing is counted in i_clk cycles.
`timescale 1ns/100ps
module pewc_mem_model #(
    parameter int FAST_CYC = 20,
    parameter int SLOW_CYC = 300
) (
    // Clock and speed
    input  wire logic                    i_clk,
    input  wire logic                    i_slow,
    // Device pins
    input  wire pewc_pkg::pewc_pins_type i_pins,
    output logic [7:0]                   o_data = 8'h00
);
    logic [7:0]  mem [0:2047] = '{default: 8'h00};
    logic [7:0]  id_mem [0:31] = '{default: 8'h00};
    logic [10:0] lat_addr;
    logic        lat_id;
    logic [7:0]  lat_data;
    logic        we_q = 1'b1;
    logic        hv_q = 1'b0;
    int          busy = 0;
    // Supply is taken as above the trip, and a strobe lasting a clock beats the filter.
    always @(posedge i_clk) begin
        we_q <= i_pins.write_n;
        hv_q <= i_pins.out_gate_hv;
        busy <= busy > 0 ? busy - 1 : 0;
        if (busy == 1 && lat_id)
            id_mem[lat_addr[4:0]] <= lat_data;
        else if (busy == 1)
            mem[lat_addr] <= lat_data;
        if (we_q && !i_pins.write_n) begin
            lat_addr <= i_pins.addr;
            lat_id   <= i_pins.id_row_hv_select;
        end
        if (!we_q && i_pins.write_n && !i_pins.chip_sel_n && i_pins.out_gate_n && !hv_q && busy == 0) begin
            lat_data <= i_pins.data_out;
            busy     <= i_slow ? SLOW_CYC : FAST_CYC;
        end
        if (i_pins.out_gate_hv && !i_pins.write_n && !i_pins.chip_sel_n)
            mem <= '{default: 8'hff};
        // A released bus shows the inverse of its last value, never a stale copy.
        if (i_pins.chip_sel_n || i_pins.out_gate_n || !i_pins.write_n)
            o_data <= ~o_data;
        else if (busy > 0 && i_pins.addr == lat_addr)
            o_data <= {~lat_data[7], ~o_data[6:0]};
        else
            o_data <= i_pins.id_row_hv_select ? id_mem[i_pins.addr[4:0]] : mem[i_pins.addr];
    end
endmodule : pewc_mem_model

// ==== tb/tb.sv ====
// Self-checking bench: controller against the behavioural EEPROM model.
// Assumes package, controller, checker and model are compiled first.
`timescale 1ns/100ps
`define CHK(got, exp, msg) begin num_checks++; if ((got) !== (exp)) begin fail_count++; \
    $display("mismatch t=%0t %s", $time, msg); end end
module tb;
    logic                    i_clk;
    logic                    i_resetn = 1'b0;
    logic                    i_req_valid = 1'b0;
    pewc_pkg::pewc_req_type  i_req = '0;
    logic                    o_req_ready;
    logic                    o_rsp_valid;
    pewc_pkg::pewc_rsp_type  o_rsp;
    pewc_pkg::pewc_pins_type o_pins;
    logic [7:0]              i_data_in;
    logic                    slow = 1'b0;
    pewc_pkg::pewc_rsp_type  rsp;
    int                      fail_count = 0;
    int                      num_checks = 0;
    int                      cycles = 0;
    pewc_ctrl #(.TIMEOUT_CYCLES(50), .CLEAR_CYCLES(4)) DUT (.i_clk(i_clk), .i_resetn(i_resetn),
        .i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(o_req_ready), .o_rsp_valid(o_rsp_valid),
        .o_rsp(o_rsp), .o_pins(o_pins), .i_data_in(i_data_in));
    pewc_mem_model u_mem (.i_clk(i_clk), .i_slow(slow), .i_pins(o_pins), .o_data(i_data_in));
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : conclude
    task automatic do_req(input pewc_pkg::pewc_cmd_type c, input logic id, input logic [10:0] a,
                          input logic [7:0] d);
        int n;
        @(posedge i_clk);
        i_req_valid <= 1'b1;
        i_req       <= {c, id, a, d};
        n = 0;
        do begin
            @(negedge i_clk);
            n++;
        end while (o_req_ready !== 1'b1 && n < 100);
        @(posedge i_clk);
        i_req_valid <= 1'b0;
        n = 0;
        do begin
            @(negedge i_clk);
            n++;
        end while (o_rsp_valid !== 1'b1 && n < 1000);
        rsp = o_rsp;
        `CHK(o_rsp_valid, 1'b1, "no answer")
    endtask : do_req
    task automatic wr(input logic id, input logic [10:0] a, input logic [7:0] d);
        do_req(pewc_pkg::PEWC_CMD_WRITE, id, a, d);
        `CHK(rsp.ok, 1'b1, "write")
    endtask : wr
    task automatic rd(input logic id, input logic [10:0] a, input logic [7:0] e);
        do_req(pewc_pkg::PEWC_CMD_READ, id, a, 8'h00);
        `CHK(rsp.data, e, "read")
    endtask : rd
    task automatic t_write_read();
        wr(1'b0, 11'h123, 8'h5a);
        wr(1'b0, 11'h7e5, 8'ha5);
        rd(1'b0, 11'h123, 8'h5a);
        rd(1'b0, 11'h7e5, 8'ha5);
        $display("test write_read done");
    endtask : t_write_read
    task automatic t_id_row();
        wr(1'b1, 11'h005, 8'h3c);
        rd(1'b1, 11'h005, 8'h3c);
        rd(1'b0, 11'h7e5, 8'ha5);
        $display("test id_row done");
    endtask : t_id_row
    task automatic t_clear();
        do_req(pewc_pkg::PEWC_CMD_CLEAR, 1'b0, 11'h000, 8'h00);
        `CHK(rsp.ok, 1'b1, "clear")
        rd(1'b0, 11'h123, 8'hff);
        rd(1'b0, 11'h7e5, 8'hff);
        rd(1'b1, 11'h005, 8'h3c);
        $display("test clear done");
    endtask : t_clear
    task automatic t_timeout();
        slow <= 1'b1;
        do_req(pewc_pkg::PEWC_CMD_WRITE, 1'b0, 11'h0aa, 8'h81);
        `CHK({rsp.ok, rsp.timeout}, 2'b01, "poll limit")
        do_req(pewc_pkg::PEWC_CMD_READ, 1'b0, 11'h0aa, 8'h00);
        `CHK(rsp.data[7], 1'b0, "busy poll")
        repeat (400) @(posedge i_clk);
        slow <= 1'b0;
        rd(1'b0, 11'h0aa, 8'h81);
        $display("test timeout done");
    endtask : t_timeout
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    // The ceiling leaves ample room over the well under one thousand cycles the tests need.
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            conclude();
        end
    end
    initial begin
        repeat (5) @(posedge i_clk);
        i_resetn <= 1'b1;
        t_write_read();
        t_id_row();
        t_clear();
        t_timeout();
        conclude();
    end
endmodule : tb
